// ===== hsr_register_bank.sv
`timescale 1ns/1ps
// What this block does
// - Fields are read, read-to-clear, or write.
// - Bits 14-12 pick 1x to 32x averaging.
// - Unused 3-bit codes act as 000b.
// - 1x gives 10 ksps three-axis, 20 single.
// - Bits 9-8 pick magnet temperature coefficient.
// - Bits 6-4 pick the seven operating states.
// - States 0,1,3 convert only on trigger.
// - State 2 converts continuously.
// - State 4 alternates converting and sleeping.
// - Deep sleep wakes only on chip select.
// - Bit 3 enables the temperature channel.
// - Bit 2 sets temperature sampling rate.
// - Bit 1 enables temperature limit check.
// - Operation register reads zero after reset.
// - 16-bit registers, read data in same frame.

module hsr_register_bank #(
    parameter int RATE_SCALE   = 1,
    parameter int SLEEP_CYCLES = hsr_pkg::SLEEP_CYCLES
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // Serial port
    input  wire logic                 spi_cs_n,
    input  wire logic                 spi_sck,
    input  wire logic                 spi_sdi,
    output logic                      spi_sdo,
    output logic                      spi_sdo_oe_n,
    // Sensor core state
    input  wire logic [15:0]          conv_state_in,
    input  wire logic [15:0]          x_result_in,
    input  wire logic [15:0]          y_result_in,
    input  wire logic [15:0]          z_result_in,
    input  wire logic [15:0]          temp_result_in,
    input  wire logic [15:0]          front_end_in,
    input  wire logic [15:0]          system_state_in,
    input  wire logic [15:0]          osc_check_in,
    input  wire logic [15:0]          angle_in,
    input  wire logic [15:0]          magnitude_in,
    input  wire logic                 conv_trigger,
    // Core control
    output hsr_pkg::hsr_op_cfg_s      op_cfg,
    output logic [15:0]               channel_setup,
    output logic [15:0]               system_setup,
    output logic [15:0]               alert_setup,
    output logic [15:0]               gain_setup,
    output logic [15:0]               offset_setup,
    output logic                      conv_start,
    output logic                      core_awake,
    output logic                      read_clear,
    output logic [6:0]                read_clear_addr
);
    import hsr_pkg::*;

    // ========================================================
    // Helpers
    function automatic logic [3:0] crc4(input logic [27:0] frame);
        logic [31:0] pad;
        logic [3:0]  c;
        logic        inv;
        pad = {frame, 4'h0};
        c   = CRC_INIT;
        for (int i = 31; i >= 0; i--) begin
            inv  = pad[i] ^ c[3];
            c[3] = c[2];
            c[2] = c[1];
            c[1] = c[0] ^ inv;
            c[0] = inv;
        end
        crc4 = c;
    endfunction

    function automatic logic [2:0] legal3(input logic [2:0] code, input logic [2:0] max);
        legal3 = (code > max) ? 3'h0 : code;
    endfunction

    // Reserved bits drop; unused 3-bit codes fall back to zero
    function automatic logic [15:0] op_word(input logic [15:0] d);
        logic [15:0] w;
        w              = d & DEVICE_SETUP_MASK;
        w[AVG_LSB+:3]  = legal3(d[AVG_LSB+:3], AVG_MAX_CODE);
        w[MODE_LSB+:3] = legal3(d[MODE_LSB+:3], MODE_MAX_CODE);
        op_word        = w;
    endfunction

    // ========================================================
    // Storage
    logic [15:0] device_setup_r;
    logic [15:0] channel_setup_r;
    logic [15:0] system_setup_r;
    logic [15:0] alert_setup_r;
    logic [15:0] thr_r [4];
    logic [15:0] test_setup_r;
    logic [15:0] gain_setup_r;
    logic [15:0] offset_setup_r;

    // Serial engine
    logic        sck_prev_r;
    logic        cs_prev_r;
    logic [5:0]  bit_cnt_r;
    logic [31:0] rx_r;
    logic [31:0] tx_r;
    logic        crc_err_r;
    logic        sdo_r;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_fall;
    logic        cs_rise;
    logic        frame_done;
    logic        frame_ok;
    logic        is_read;
    logic [6:0]  frame_addr;
    logic [15:0] frame_data;
    logic [15:0] rd_data;
    logic [6:0]  early_addr;
    logic [27:0] tx_body;

    assign sck_rise   = ~spi_cs_n & spi_sck & ~sck_prev_r;
    assign sck_fall   = ~spi_cs_n & ~spi_sck & sck_prev_r;
    assign cs_fall    = ~spi_cs_n & cs_prev_r;
    assign cs_rise    = spi_cs_n & ~cs_prev_r;
    assign is_read    = rx_r[31];
    assign frame_addr = rx_r[30:24];
    assign frame_data = rx_r[23:8];
    assign frame_done = cs_rise && bit_cnt_r == 6'(FRAME_BITS);
    assign frame_ok   = test_setup_r[CRC_OFF_BIT] || crc4(rx_r[31:4]) == rx_r[3:0];
    assign early_addr = {rx_r[5:0], spi_sdi};

    // ========================================================
    // Read decode
    always_comb begin
        case (early_addr)
            ADDR_DEVICE_SETUP:  rd_data = device_setup_r & DEVICE_SETUP_MASK;
            ADDR_CHANNEL_SETUP: rd_data = channel_setup_r;
            ADDR_SYSTEM_SETUP:  rd_data = system_setup_r;
            ADDR_ALERT_SETUP:   rd_data = alert_setup_r;
            ADDR_X_THRESHOLD:   rd_data = thr_r[0];
            ADDR_Y_THRESHOLD:   rd_data = thr_r[1];
            ADDR_Z_THRESHOLD:   rd_data = thr_r[2];
            ADDR_T_THRESHOLD:   rd_data = thr_r[3];
            ADDR_CONV_STATE:    rd_data = conv_state_in;
            ADDR_X_RESULT:      rd_data = x_result_in;
            7'h0A:              rd_data = y_result_in;
            7'h0B:              rd_data = z_result_in;
            7'h0C:              rd_data = temp_result_in;
            ADDR_FRONT_END:     rd_data = front_end_in;
            ADDR_SYSTEM_STATE:  rd_data = system_state_in;
            ADDR_TEST_SETUP:    rd_data = test_setup_r;
            ADDR_OSC_CHECK:     rd_data = osc_check_in;
            ADDR_GAIN_SETUP:    rd_data = gain_setup_r;
            ADDR_OFFSET_SETUP:  rd_data = offset_setup_r;
            ADDR_ANGLE:         rd_data = angle_in;
            ADDR_LAST:          rd_data = magnitude_in;
            default:            rd_data = 16'h0000;
        endcase
    end

    // Read of a write frame shows zeros in the data field
    assign tx_body = {tx_r[31:20], rx_r[6] ? rd_data : 16'h0000};

    // ========================================================
    // Frame bit counter and receive shift register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sck_prev_r <= 1'b0;
            cs_prev_r  <= 1'b1;
            bit_cnt_r  <= 6'h00;
            rx_r       <= 32'h0000_0000;
        end else begin
            sck_prev_r <= spi_sck;
            cs_prev_r  <= spi_cs_n;
            if (cs_fall) begin
                bit_cnt_r <= 6'h00;
            end else if (sck_rise && bit_cnt_r != 6'(FRAME_BITS)) begin
                bit_cnt_r <= bit_cnt_r + 6'h01;
                rx_r      <= {rx_r[30:0], spi_sdi};
            end
        end
    end

    // Previous frame CRC status travels in the next status field
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            crc_err_r <= 1'b0;
        end else if (frame_done) begin
            crc_err_r <= ~frame_ok;
        end
    end

    // Data known after the address byte, well before bit 19 leaves
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_r <= 32'h0000_0000;
        end else if (cs_fall) begin
            tx_r <= {crc_err_r, 31'h0};
        end else if (sck_rise && bit_cnt_r == 6'(ADDR_DONE_BITS - 1)) begin
            tx_r <= {tx_body, crc4(tx_body)};
        end
    end

    // Output changes on falling clock so the controller samples on rising
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sdo_r <= 1'b0;
        end else if (cs_fall) begin
            sdo_r <= crc_err_r;
        end else if (sck_fall && bit_cnt_r < 6'(FRAME_BITS)) begin
            sdo_r <= tx_r[5'(31 - bit_cnt_r)];
        end
    end

    assign spi_sdo      = sdo_r;
    assign spi_sdo_oe_n = spi_cs_n;

    // ========================================================
    // Operation register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            device_setup_r <= DEVICE_SETUP_RST;
        end else if (frame_done && frame_ok && !is_read && frame_addr == ADDR_DEVICE_SETUP) begin
            device_setup_r <= op_word(frame_data);
        end else if (cs_fall && device_setup_r[MODE_LSB+:3] == HSR_DEEP_SLEEP) begin
            device_setup_r[MODE_LSB+:3] <= HSR_CONFIG;
        end
    end

    // ========================================================
    // Other writable registers; reserved and read-only offsets drop writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            channel_setup_r <= 16'h0000;
            system_setup_r  <= 16'h0000;
            alert_setup_r   <= 16'h0000;
            thr_r           <= '{default: 16'h0000};
            test_setup_r    <= 16'h0000;
            gain_setup_r    <= 16'h0000;
            offset_setup_r  <= 16'h0000;
        end else if (frame_done && frame_ok && !is_read) begin
            case (frame_addr)
                ADDR_CHANNEL_SETUP: channel_setup_r <= frame_data;
                ADDR_SYSTEM_SETUP:  system_setup_r  <= frame_data;
                ADDR_ALERT_SETUP:   alert_setup_r   <= frame_data;
                ADDR_X_THRESHOLD:   thr_r[0]        <= frame_data;
                ADDR_Y_THRESHOLD:   thr_r[1]        <= frame_data;
                ADDR_Z_THRESHOLD:   thr_r[2]        <= frame_data;
                ADDR_T_THRESHOLD:   thr_r[3]        <= frame_data;
                ADDR_TEST_SETUP:    test_setup_r    <= frame_data;
                ADDR_GAIN_SETUP:    gain_setup_r    <= frame_data;
                ADDR_OFFSET_SETUP:  offset_setup_r  <= frame_data;
                default: begin
                end
            endcase
        end
    end

    // ========================================================
    // Read-to-clear strobe for status registers, after the data has left
    logic rc_hit;

    assign rc_hit = frame_addr == ADDR_CONV_STATE || frame_addr == ADDR_FRONT_END
        || frame_addr == ADDR_SYSTEM_STATE;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            read_clear      <= 1'b0;
            read_clear_addr <= 7'h00;
        end else begin
            read_clear <= frame_done && frame_ok && is_read && rc_hit;
            if (frame_done) begin
                read_clear_addr <= frame_addr;
            end
        end
    end

    // ========================================================
    // Decoded configuration to the core
    always_comb begin
        op_cfg.averaging_count                = device_setup_r[AVG_LSB+:3];
        op_cfg.magnet_temp_coefficient        = device_setup_r[COEF_LSB+:2];
        op_cfg.mode                           = hsr_mode_e'(device_setup_r[MODE_LSB+:3]);
        op_cfg.temperature_channel_enable     = device_setup_r[TEMP_EN_BIT];
        op_cfg.temperature_rate_once          = device_setup_r[TEMP_RATE_BIT];
        op_cfg.temperature_limit_check_enable = device_setup_r[TEMP_LIMIT_BIT];
    end

    assign channel_setup = channel_setup_r;
    assign system_setup  = system_setup_r;
    assign alert_setup   = alert_setup_r;
    assign gain_setup    = gain_setup_r;
    assign offset_setup  = offset_setup_r;

    logic [3:0] chan_code;
    logic       single_axis;

    // Single-axis codes get the faster rate table
    assign chan_code   = channel_setup_r[CHAN_EN_LSB+:4];
    assign single_axis = chan_code == 4'h1 || chan_code == 4'h2 || chan_code == 4'h4;

    hsr_pacer #(
        .RATE_SCALE   (RATE_SCALE),
        .SLEEP_CYCLES (SLEEP_CYCLES)
    ) u_pacer (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .cfg         (op_cfg),
        .single_axis (single_axis),
        .trigger     (conv_trigger),
        .conv_start  (conv_start),
        .awake       (core_awake)
    );

endmodule // hsr_register_bank

// ===== hsr_pkg.sv
package hsr_pkg;

    // ========================================================
    // Register offsets
    localparam logic [6:0] ADDR_DEVICE_SETUP   = 7'h00;
    localparam logic [6:0] ADDR_CHANNEL_SETUP  = 7'h01;
    localparam logic [6:0] ADDR_SYSTEM_SETUP   = 7'h02;
    localparam logic [6:0] ADDR_ALERT_SETUP    = 7'h03;
    localparam logic [6:0] ADDR_X_THRESHOLD    = 7'h04;
    localparam logic [6:0] ADDR_Y_THRESHOLD    = 7'h05;
    localparam logic [6:0] ADDR_Z_THRESHOLD    = 7'h06;
    localparam logic [6:0] ADDR_T_THRESHOLD    = 7'h07;
    localparam logic [6:0] ADDR_CONV_STATE     = 7'h08;
    localparam logic [6:0] ADDR_X_RESULT       = 7'h09;
    localparam logic [6:0] ADDR_FRONT_END      = 7'h0D;
    localparam logic [6:0] ADDR_SYSTEM_STATE   = 7'h0E;
    localparam logic [6:0] ADDR_TEST_SETUP     = 7'h0F;
    localparam logic [6:0] ADDR_OSC_CHECK      = 7'h10;
    localparam logic [6:0] ADDR_GAIN_SETUP     = 7'h11;
    localparam logic [6:0] ADDR_OFFSET_SETUP   = 7'h12;
    localparam logic [6:0] ADDR_ANGLE          = 7'h13;
    localparam logic [6:0] ADDR_LAST           = 7'h14;
    localparam int         NUM_REGS            = 21;

    // ========================================================
    // Operation register layout, then channel setup and test setup bits
    localparam int          AVG_LSB            = 12;
    localparam int          COEF_LSB           = 8;
    localparam int          MODE_LSB           = 4;
    localparam int          TEMP_EN_BIT        = 3;
    localparam int          TEMP_RATE_BIT      = 2;
    localparam int          TEMP_LIMIT_BIT     = 1;
    localparam logic [15:0] DEVICE_SETUP_RST   = 16'h0000;
    localparam logic [15:0] DEVICE_SETUP_MASK  = 16'h737E;
    localparam logic [2:0]  AVG_MAX_CODE       = 3'h5;
    localparam logic [2:0]  MODE_MAX_CODE      = 3'h6;
    localparam int          CHAN_EN_LSB        = 6;
    localparam int          CRC_OFF_BIT        = 2;

    // ========================================================
    // Frame layout and CRC
    localparam int          FRAME_BITS         = 32;
    localparam int          ADDR_DONE_BITS     = 8;
    localparam logic [3:0]  CRC_INIT           = 4'hF;

    // ========================================================
    // Timing: sample rates in samples per second
    localparam int          CLK_HZ             = 40_000_000;
    localparam int          SLEEP_TIME_US      = 1000;
    localparam int          SLEEP_CYCLES       = (CLK_HZ / 1_000_000) * SLEEP_TIME_US;
    localparam int          RATE3_SPS [6]      = '{10000, 5700, 3100, 1600, 800, 400};
    localparam int          RATE1_SPS [6]      = '{20000, 13300, 8000, 4400, 2400, 1200};

    typedef enum logic [2:0] {
        HSR_CONFIG     = 3'b000,
        HSR_STANDBY    = 3'b001,
        HSR_CONTINUOUS = 3'b010,
        HSR_TRIGGERED  = 3'b011,
        HSR_DUTY       = 3'b100,
        HSR_SLEEP      = 3'b101,
        HSR_DEEP_SLEEP = 3'b110
    } hsr_mode_e;

    typedef struct packed {
        logic [2:0] averaging_count;
        logic [1:0] magnet_temp_coefficient;
        hsr_mode_e  mode;
        logic       temperature_channel_enable;
        logic       temperature_rate_once;
        logic       temperature_limit_check_enable;
    } hsr_op_cfg_s;

endpackage

// ===== hsr_pacer.sv
`timescale 1ns/1ps

module hsr_pacer #(
    parameter int RATE_SCALE   = 1,
    parameter int SLEEP_CYCLES = hsr_pkg::SLEEP_CYCLES
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                sys_rst,
    // Configuration
    input  wire hsr_pkg::hsr_op_cfg_s cfg,
    input  wire logic                single_axis,
    input  wire logic                trigger,
    // Conversion control
    output logic                     conv_start,
    output logic                     awake
);
    import hsr_pkg::*;

    initial begin
        if (RATE_SCALE < 1 || SLEEP_CYCLES < 1) begin
            $error("hsr_pacer: scale and sleep count must be positive");
        end
    end

    function automatic logic [31:0] period_cycles(input logic [2:0] avg, input logic one);
        int sps;
        sps = one ? RATE1_SPS[avg] : RATE3_SPS[avg];
        period_cycles = 32'(CLK_HZ / sps / RATE_SCALE);
    endfunction

    logic [31:0] cnt_r;
    logic        sleeping_r;
    logic [31:0] period;

    assign period = period_cycles(cfg.averaging_count, single_axis);

    // ========================================================
    // Conversion timing per mode
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r      <= 32'h0;
            sleeping_r <= 1'b0;
            conv_start <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            case (cfg.mode)
                HSR_CONTINUOUS: begin
                    sleeping_r <= 1'b0;
                    if (cnt_r >= period - 32'h1) begin
                        cnt_r      <= 32'h0;
                        conv_start <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r + 32'h1;
                    end
                end
                HSR_DUTY: begin
                    if (cnt_r >= (sleeping_r ? 32'(SLEEP_CYCLES) : period) - 32'h1) begin
                        cnt_r      <= 32'h0;
                        sleeping_r <= ~sleeping_r;
                        conv_start <= sleeping_r;
                    end else begin
                        cnt_r <= cnt_r + 32'h1;
                    end
                end
                HSR_CONFIG, HSR_STANDBY, HSR_TRIGGERED: begin
                    cnt_r      <= 32'h0;
                    sleeping_r <= 1'b0;
                    conv_start <= trigger;
                end
                default: begin
                    cnt_r      <= 32'h0;
                    sleeping_r <= 1'b1;
                end
            endcase
        end
    end

    // Sleep and deep sleep hold the core powered down
    assign awake = ~sleeping_r && cfg.mode != HSR_SLEEP && cfg.mode != HSR_DEEP_SLEEP;

endmodule // hsr_pacer

// ===== hsr_spi_host.sv
`timescale 1ns/1ps
// ========================================
// Controller side of the serial port
module hsr_spi_host (
    // Clock
    input  wire logic clk,
    // Serial port
    output logic      cs_n,
    output logic      sck,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        sdi  = 1'b0;
    end

    function automatic logic [3:0] crc4(input logic [27:0] f);
        logic [31:0] p;
        logic [3:0]  c;
        logic        v;
        p = {f, 4'h0};
        c = 4'hF;
        for (int i = 31; i >= 0; i--) begin
            v = p[i] ^ c[3];
            c = {c[2:1], c[0] ^ v, v};
        end
        return c;
    endfunction

    // Only mapped offsets are ever sent by callers
    task automatic frame(input logic [27:0] b, input logic bad, output logic [31:0] rx);
        logic [31:0] tx;
        tx = {b, crc4(b) ^ {3'h0, bad}};
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 31; i >= 0; i--) begin
            sdi <= tx[i];
            repeat (2) @(posedge clk);
            rx[i] = sdo;
            sck <= 1'b1;
            repeat (2) @(posedge clk);
            sck <= 1'b0;
        end
        repeat (2) @(posedge clk);
        cs_n <= 1'b1;
        // Released line must not look like held data
        sdi  <= ~tx[0];
        repeat (3) @(posedge clk);
    endtask
endmodule // hsr_spi_host

// ===== hsr_register_bank_props.sv
`timescale 1ns/1ps
// ========================================
// Port checker
module hsr_register_bank_props #(
    parameter int RATE_SCALE = 1
) (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 sys_rst,
    // Watched ports
    input wire logic                 spi_cs_n,
    input wire logic                 spi_sdo_oe_n,
    input wire logic                 conv_trigger,
    input wire hsr_pkg::hsr_op_cfg_s op_cfg,
    input wire logic                 conv_start,
    input wire logic                 core_awake,
    input wire logic                 read_clear,
    input wire logic [6:0]           read_clear_addr
);
    import hsr_pkg::*;
    // Slack for an averaging change in mid-period
    localparam int GAP = 2 * (CLK_HZ / 400 / RATE_SCALE) + 2;
    int   gap_r;
    logic trig_mode;
    assign trig_mode = op_cfg.mode inside {HSR_CONFIG, HSR_STANDBY, HSR_TRIGGERED};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gap_r <= 0;
        end else if (conv_start || op_cfg.mode != HSR_CONTINUOUS) begin
            gap_r <= 0;
        end else begin
            gap_r <= gap_r + 1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    oe_follow_a: assert property (spi_sdo_oe_n == spi_cs_n)
        else $error("SDO enable does not follow chip select");
    avg_code_a: assert property (op_cfg.averaging_count <= 3'h5)
        else $error("Averaging code out of range");
    mode_code_a: assert property (op_cfg.mode != 3'h7)
        else $error("Unused mode code kept");
    rst_value_a: assert property ($fell(sys_rst) |-> op_cfg == '0 && core_awake)
        else $error("Operation setup not zero after reset");
    trig_only_a: assert property (conv_start && trig_mode && $past(trig_mode) &&
        $past(trig_mode, 2) |-> $past(conv_trigger) || $past(conv_trigger, 2))
        else $error("Conversion without trigger");
    cont_gap_a: assert property (gap_r <= GAP)
        else $error("Continuous conversions stalled");
    deep_wake_a: assert property (op_cfg.mode == HSR_DEEP_SLEEP && $fell(spi_cs_n)
        |-> ##[0:2] op_cfg.mode == HSR_CONFIG)
        else $error("Deep sleep did not wake on select");
    deep_quiet_a: assert property ((op_cfg.mode == HSR_DEEP_SLEEP) [*3]
        |-> !core_awake && !conv_start)
        else $error("Core active in deep sleep");
    cfg_hold_a: assert property (!spi_cs_n && $past(spi_cs_n) == 1'b0 &&
        $past(op_cfg.mode) != HSR_DEEP_SLEEP |-> $stable(op_cfg))
        else $error("Setup changed inside a frame");
    clear_addr_a: assert property (read_clear |-> spi_cs_n &&
        read_clear_addr inside {7'h08, 7'h0D, 7'h0E})
        else $error("Clear pulse for wrong offset");

    cover property (conv_start && op_cfg.mode == HSR_CONTINUOUS);
    cover property (read_clear);
    cover property (op_cfg.mode == HSR_DUTY && !core_awake);
endmodule // hsr_register_bank_props

bind hsr_register_bank hsr_register_bank_props #(.RATE_SCALE(RATE_SCALE)) u_props (
    .clk, .sys_rst, .spi_cs_n, .spi_sdo_oe_n, .conv_trigger, .op_cfg,
    .conv_start, .core_awake, .read_clear, .read_clear_addr);

// ===== hall_sensor_register_bank_tb.sv
`timescale 1ns/1ps
// ========================================
// Bench top
module hall_sensor_register_bank_tb;
    import hsr_pkg::*;
    localparam int RS = 100;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cs_n, sck, sdi, sdo, oe_n, rclr, awake, conv_start;
    logic        trig = 1'b0;
    logic [15:0] ro [21];
    logic [15:0] regs [21];
    logic [15:0] ch_o, sy_o, al_o, ga_o, of_o;
    logic [6:0]  rclr_addr;
    logic [6:0]  rc_seen = 7'h7F;
    logic [31:0] lfsr = 32'hAE01CEF2;
    logic [31:0] rx;
    hsr_op_cfg_s op_cfg;
    int          err_count = 0;
    int          cmp_count = 0;
    int          nstart = 0;
    int          nsleep = 0;

    always #12.5 clk = ~clk;

    hsr_register_bank #(.RATE_SCALE(RS), .SLEEP_CYCLES(50)) dut (
        .clk, .sys_rst, .spi_cs_n(cs_n), .spi_sck(sck), .spi_sdi(sdi),
        .spi_sdo(sdo), .spi_sdo_oe_n(oe_n), .conv_state_in(ro[8]),
        .x_result_in(ro[9]), .y_result_in(ro[10]), .z_result_in(ro[11]),
        .temp_result_in(ro[12]), .front_end_in(ro[13]), .system_state_in(ro[14]),
        .osc_check_in(ro[16]), .angle_in(ro[19]), .magnitude_in(ro[20]),
        .conv_trigger(trig), .op_cfg, .channel_setup(ch_o), .system_setup(sy_o),
        .alert_setup(al_o), .gain_setup(ga_o), .offset_setup(of_o), .conv_start,
        .core_awake(awake), .read_clear(rclr), .read_clear_addr(rclr_addr));
    hsr_spi_host u_host (.clk, .cs_n, .sck, .sdi, .sdo);

    always @(posedge clk) begin
        if (rclr === 1'b1) rc_seen <= rclr_addr;
        if (conv_start === 1'b1) nstart <= nstart + 1;
        if (awake === 1'b0) nsleep <= nsleep + 1;
    end

    function automatic logic [15:0] nx();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[15:0];
    endfunction

    // Reserved bits dropped, unused codes fall back to zero
    function automatic logic [15:0] op_exp(input logic [15:0] d);
        logic [15:0] e;
        e = d & 16'h737E;
        if (d[14:12] > 3'h5) e[14:12] = 3'h0;
        if (d[6:4] == 3'h7) e[6:4] = 3'h0;
        return e;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic bad);
        u_host.frame({1'b0, a, d, 4'h0}, bad, rx);
        check(rx[19:4], 16'h0);
    endtask

    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        u_host.frame({1'b1, a, 16'h0, 4'h0}, 1'b0, rx);
        d = rx[19:4];
    endtask

    task automatic finish_test();
        if (err_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        finish_test();
    end

    initial begin
        logic [15:0] d, e;
        int          n0, p;
        for (int i = 0; i < 21; i++) ro[i] = nx();
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        check(op_cfg, 11'h0);
        rd(7'h00, d);
        check(d, 16'h0);
        // Every averaging and mode code, random other bits
        for (int i = 0; i < 8; i++) begin
            d = nx();
            d[14:12] = i[2:0];
            d[6:4] = i[2:0];
            e = op_exp(d);
            wr(7'h00, d, 1'b0);
            check(op_cfg, {e[14:12], e[9:8], e[6:4], e[3:1]});
            if (i == 6) begin
                repeat (2) @(posedge clk);
                check(awake, 1'b0);
                e[6:4] = 3'h0;
            end
            rd(7'h00, d);
            check(d, e);
        end
        // Corrupted write is dropped and flagged in the next frame
        wr(7'h01, nx(), 1'b1);
        rd(7'h01, d);
        check(d, 16'h0);
        check(rx[31], 1'b1);
        for (int a = 1; a < 21; a++) begin
            d = nx();
            wr(a[6:0], d, 1'b0);
            regs[a] = (a < 8 || a == 15 || a == 17 || a == 18) ? d : ro[a];
            rd(a[6:0], e);
            check(e, regs[a]);
            if (a == 8 || a == 13 || a == 14) check(rc_seen, a[6:0]);
        end
        check({ch_o, sy_o}, {regs[1], regs[2]});
        check({al_o, ga_o}, {regs[3], regs[17]});
        check(of_o, regs[18]);
        // Continuous pacing: three axes at 1x and 2x, then one axis at 1x
        for (int v = 0; v < 3; v++) begin
            wr(7'h01, {9'h0, v[1], 6'h0}, 1'b0);
            wr(7'h00, {1'b0, 2'h0, v[0], 12'h020}, 1'b0);
            p = CLK_HZ / (v[1] ? RATE1_SPS[0] : RATE3_SPS[v]) / RS;
            n0 = nstart;
            repeat (10 * p) @(posedge clk);
            check(nstart - n0 >= 9 && nstart - n0 <= 11, 1'b1);
        end
        wr(7'h00, 16'h0030, 1'b0);
        n0 = nstart;
        repeat (200) @(posedge clk);
        check(nstart - n0, 0);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        repeat (5) @(posedge clk);
        check(nstart - n0, 1);
        wr(7'h00, 16'h0040, 1'b0);
        n0 = nstart;
        p = nsleep;
        repeat (1000) @(posedge clk);
        check(nsleep > p && nstart > n0, 1'b1);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        check({op_cfg, awake, ch_o}, {11'h0, 1'b1, 16'h0});
        finish_test();
    end
endmodule // hall_sensor_register_bank_tb
